// File: line_irq_pkg.sv
// constants, offsets and field layout for the line interface interrupt logic
//
// Notes on behaviour
// RQ1 - thirteen event sources: line, ring trip, power, tone digit, eight timers, indirect access
// RQ2 - three status and three enable registers, one bit per source
// RQ3 - a status bit reads one while its source is pending, else zero
// RQ4 - enable bits are active high; zero suppresses the source
// RQ5 - an event sets its status bit only while its enable bit is one
// RQ6 - interrupt pin is the NOR of all status bits, low while any is set
// RQ7 - host handler reads the status registers after seeing the pin low
// RQ8 - writing one clears that status bit, writing zero leaves it alone
// RQ9 - a tone digit event loads the digit register, a later digit overwrites it
// RQ10 - a status bit holds until cleared; an event beside a clear keeps it set

package line_irq_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // bus and source widths
   localparam int DATA_W = 8;
   localparam int ADDR_W = 3;
   localparam int NUM_SRC = 13;
   localparam int DIGIT_W = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [ADDR_W-1:0] STATUS0_ADDR = 3'h0;
   localparam logic [ADDR_W-1:0] STATUS1_ADDR = 3'h1;
   localparam logic [ADDR_W-1:0] STATUS2_ADDR = 3'h2;
   localparam logic [ADDR_W-1:0] ENABLE0_ADDR = 3'h3;
   localparam logic [ADDR_W-1:0] ENABLE1_ADDR = 3'h4;
   localparam logic [ADDR_W-1:0] ENABLE2_ADDR = 3'h5;
   localparam logic [ADDR_W-1:0] DIGIT_ADDR = 3'h6;

   ////////////////////////////////////////////////////////////////////////////////
   // where each register's bits sit in the source vector
   localparam int REG0_LSB = 0;
   localparam int REG0_N = 8;
   localparam int REG1_LSB = 8;
   localparam int REG1_N = 4;
   localparam int REG2_LSB = 12;
   localparam int REG2_N = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // source index in the event and status vectors
   localparam int SRC_T1_ACT = 0;
   localparam int SRC_T1_INACT = 1;
   localparam int SRC_T2_ACT = 2;
   localparam int SRC_T2_INACT = 3;
   localparam int SRC_RING_ACT = 4;
   localparam int SRC_RING_INACT = 5;
   localparam int SRC_METER_ACT = 6;
   localparam int SRC_METER_INACT = 7;
   localparam int SRC_LOOP = 8;
   localparam int SRC_RING_TRIP = 9;
   localparam int SRC_POWER_ALARM = 10;
   localparam int SRC_IND_DONE = 11;
   localparam int SRC_TONE_DIGIT = 12;

   ////////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [NUM_SRC-1:0] STATUS_RST = 13'h0000;
   localparam logic [NUM_SRC-1:0] ENABLE_RST = 13'h0000;
   localparam logic [DIGIT_W-1:0] DIGIT_RST = 4'h0;
   localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

endpackage

// File: sticky_flag_bank.sv
// bank of sticky pending flags, set by events and cleared by writing ones
`timescale 1ns/1ns
`default_nettype none

module sticky_flag_bank #(
   parameter int N = 13
) (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic [N-1:0] set_in,
   input wire logic [N-1:0] clr_in,
   output logic [N-1:0] flag_out
);

   logic [N-1:0] flag_ff;
   logic [N-1:0] nxt_flag;

   ////////////////////////////////////////////////////////////////////////////////
   // per bit next value: set beats clear, else hold
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_bit
         assign nxt_flag[i] = set_in[i] | (flag_ff[i] & ~clr_in[i]); // RQ10
      end
   endgenerate

   // flag registers
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
      begin
         flag_ff <= '0;
      end
      else if (ce_in)
      begin
         flag_ff <= nxt_flag;
      end
   end

   assign flag_out = flag_ff;

endmodule // sticky_flag_bank

`default_nettype wire

// File: digit_latch.sv
// single entry holder for the last detected tone digit
`timescale 1ns/1ns
`default_nettype none

module digit_latch #(
   parameter int W = 4
) (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic load_in,
   input wire logic [W-1:0] digit_in,
   output logic [W-1:0] digit_out
);

   logic [W-1:0] digit_ff;
   logic [W-1:0] nxt_digit;

   ////////////////////////////////////////////////////////////////////////////////
   // no buffering: a new digit simply overwrites the old one
   always_comb
   begin
      nxt_digit = digit_ff;
      if (load_in)
      begin
         nxt_digit = digit_in; // RQ9
      end
   end

   // digit register
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
      begin
         digit_ff <= '0;
      end
      else if (ce_in)
      begin
         digit_ff <= nxt_digit;
      end
   end

   assign digit_out = digit_ff;

endmodule // digit_latch

`default_nettype wire

// File: line_interface_interrupt_logic.sv
// interrupt aggregation: enables, sticky status, digit register and pin
`timescale 1ns/1ns
`default_nettype none

module line_interface_interrupt_logic (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic [line_irq_pkg::ADDR_W-1:0] addr_in,
   input wire logic [line_irq_pkg::DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [line_irq_pkg::DATA_W-1:0] rdata_out,
   input wire logic [line_irq_pkg::NUM_SRC-1:0] event_in,
   input wire logic [line_irq_pkg::DIGIT_W-1:0] tone_digit_in,
   output logic int_b_out
);

   import line_irq_pkg::*;

   logic [NUM_SRC-1:0] enable_ff;
   logic [NUM_SRC-1:0] nxt_enable;
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic [NUM_SRC-1:0] set_vec;
   logic [NUM_SRC-1:0] clr_vec;
   logic [NUM_SRC-1:0] pending;
   logic [DIGIT_W-1:0] digit;
   logic [DATA_W-1:0] status0_view;
   logic [DATA_W-1:0] status1_view;
   logic [DATA_W-1:0] status2_view;
   logic [DATA_W-1:0] enable0_view;
   logic [DATA_W-1:0] enable1_view;
   logic [DATA_W-1:0] enable2_view;
   logic [DATA_W-1:0] digit_view;

   ////////////////////////////////////////////////////////////////////////////////
   // register views, unused upper bits read as zero
   always_comb
   begin
      status0_view = '0;
      status1_view = '0;
      status2_view = '0;
      enable0_view = '0;
      enable1_view = '0;
      enable2_view = '0;
      digit_view = '0;
      status0_view[REG0_N-1:0] = pending[REG0_LSB +: REG0_N]; // RQ3
      status1_view[REG1_N-1:0] = pending[REG1_LSB +: REG1_N]; // RQ3
      status2_view[REG2_N-1:0] = pending[REG2_LSB +: REG2_N]; // RQ3
      enable0_view[REG0_N-1:0] = enable_ff[REG0_LSB +: REG0_N];
      enable1_view[REG1_N-1:0] = enable_ff[REG1_LSB +: REG1_N];
      enable2_view[REG2_N-1:0] = enable_ff[REG2_LSB +: REG2_N];
      digit_view[DIGIT_W-1:0] = digit;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // event gating and write-one-to-clear decode
   always_comb
   begin
      set_vec = event_in & enable_ff; // RQ5 RQ4 RQ1
      clr_vec = '0;
      if (wr_in)
      begin
         case (addr_in)
            STATUS0_ADDR: clr_vec[REG0_LSB +: REG0_N] = wdata_in[REG0_N-1:0]; // RQ8
            STATUS1_ADDR: clr_vec[REG1_LSB +: REG1_N] = wdata_in[REG1_N-1:0]; // RQ8
            STATUS2_ADDR: clr_vec[REG2_LSB +: REG2_N] = wdata_in[REG2_N-1:0]; // RQ8
            default: clr_vec = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // enable registers and read data, next values
   always_comb
   begin
      nxt_enable = enable_ff;
      nxt_rdata = RDATA_IDLE;
      if (wr_in)
      begin
         case (addr_in)
            ENABLE0_ADDR: nxt_enable[REG0_LSB +: REG0_N] = wdata_in[REG0_N-1:0]; // RQ2
            ENABLE1_ADDR: nxt_enable[REG1_LSB +: REG1_N] = wdata_in[REG1_N-1:0]; // RQ2
            ENABLE2_ADDR: nxt_enable[REG2_LSB +: REG2_N] = wdata_in[REG2_N-1:0]; // RQ2
            default: nxt_enable = enable_ff;
         endcase
      end
      if (rd_in)
      begin
         case (addr_in)
            STATUS0_ADDR: nxt_rdata = status0_view; // RQ2
            STATUS1_ADDR: nxt_rdata = status1_view;
            STATUS2_ADDR: nxt_rdata = status2_view;
            ENABLE0_ADDR: nxt_rdata = enable0_view;
            ENABLE1_ADDR: nxt_rdata = enable1_view;
            ENABLE2_ADDR: nxt_rdata = enable2_view;
            DIGIT_ADDR: nxt_rdata = digit_view;
            default: nxt_rdata = RDATA_IDLE;
         endcase
      end
   end

   // enable and read data registers
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
      begin
         enable_ff <= ENABLE_RST;
         rdata_ff <= RDATA_IDLE;
      end
      else if (ce_in)
      begin
         enable_ff <= nxt_enable;
         rdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sticky status flags
   sticky_flag_bank #(
      .N(NUM_SRC)
   ) u_flags (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .ce_in(ce_in),
      .set_in(set_vec),
      .clr_in(clr_vec),
      .flag_out(pending)
   );

   // last detected digit, loaded on every detection
   digit_latch #(
      .W(DIGIT_W)
   ) u_digit (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .ce_in(ce_in),
      .load_in(event_in[SRC_TONE_DIGIT]),
      .digit_in(tone_digit_in),
      .digit_out(digit)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign rdata_out = rdata_ff;
   assign int_b_out = ~(|pending); // RQ6

   ////////////////////////////////////////////////////////////////////////////////
   // checks on the event path
   a_enabled_event_sets: assert property ( // RQ5
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      ce_in |=> ((pending & $past(set_vec)) == $past(set_vec)))
      else $error("enabled event did not set its status bit");

   a_masked_event_ignored: assert property ( // RQ4
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      ce_in |=> ((pending & ~$past(pending) & ~$past(event_in & enable_ff)) == '0))
      else $error("status bit set without an enabled event");

   a_status_sticky: assert property ( // RQ10
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && !wr_in) |=> ((pending & $past(pending)) == $past(pending)))
      else $error("status bit dropped without a clear");

   a_set_beats_clear: assert property ( // RQ10
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && wr_in && addr_in == STATUS0_ADDR && wdata_in[SRC_T1_ACT]
         && event_in[SRC_T1_ACT] && enable_ff[SRC_T1_ACT])
      |=> pending[SRC_T1_ACT])
      else $error("event lost beside a clear");

   ////////////////////////////////////////////////////////////////////////////////
   // checks on the clearing path
   a_clear_by_ones: assert property ( // RQ8
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && wr_in && addr_in == STATUS0_ADDR && set_vec == '0)
      |=> (pending[REG0_LSB +: REG0_N]
         == ($past(pending[REG0_LSB +: REG0_N]) & ~$past(wdata_in[REG0_N-1:0]))))
      else $error("write to status did not clear exactly the one bits");

   a_clear_other_regs: assert property ( // RQ8
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && wr_in && addr_in == STATUS1_ADDR && set_vec == '0)
      |=> (pending[REG0_LSB +: REG0_N] == $past(pending[REG0_LSB +: REG0_N])
         && pending[REG2_LSB +: REG2_N] == $past(pending[REG2_LSB +: REG2_N])))
      else $error("status write touched another register");

   ////////////////////////////////////////////////////////////////////////////////
   // checks on the pin
   a_pin_low_pending: assert property ( // RQ6
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && set_vec != '0) |=> !int_b_out)
      else $error("pin not low after an enabled event");

   a_pin_high_cleared: assert property ( // RQ6
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && wr_in && addr_in == STATUS0_ADDR && wdata_in == 8'hFF
         && pending[NUM_SRC-1:REG1_LSB] == '0 && set_vec == '0)
      |=> int_b_out)
      else $error("pin not released after all bits cleared");

   ////////////////////////////////////////////////////////////////////////////////
   // checks on the register port
   a_status_readback: assert property ( // RQ3
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && rd_in && addr_in == STATUS1_ADDR)
      |=> (rdata_out == {4'h0, $past(pending[REG1_LSB +: REG1_N])}))
      else $error("status read returned the wrong value");

   a_top_status_bits: assert property ( // RQ1
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && rd_in && addr_in == STATUS2_ADDR)
      |=> (rdata_out[DATA_W-1:REG2_N] == '0))
      else $error("bits beyond the thirteen sources read nonzero");

   a_enable_readback: assert property ( // RQ2
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && wr_in && addr_in == ENABLE0_ADDR)
      ##1 (ce_in && rd_in && addr_in == ENABLE0_ADDR)
      |=> (rdata_out == $past(wdata_in, 2)))
      else $error("enable register did not read back its write");

   a_read_one_cycle: assert property (
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && !rd_in) |=> (rdata_out == RDATA_IDLE))
      else $error("read data held outside the answer cycle");

   ////////////////////////////////////////////////////////////////////////////////
   // checks on the digit register and the clock enable
   a_digit_loaded: assert property ( // RQ9
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && event_in[SRC_TONE_DIGIT])
      |=> (digit == $past(tone_digit_in)))
      else $error("digit register missed a detection");

   a_digit_held: assert property ( // RQ9
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && !event_in[SRC_TONE_DIGIT]) |=> $stable(digit))
      else $error("digit register changed without a detection");

   a_ce_freezes: assert property (
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      !ce_in |=> ($stable(pending) && $stable(enable_ff) && $stable(rdata_out)))
      else $error("state moved while clock enable low");

   ////////////////////////////////////////////////////////////////////////////////
   // checks on the status and digit registers, the enables and the pin hold
   a_clear_status1: assert property ( // RQ8
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && wr_in && addr_in == STATUS1_ADDR && set_vec == '0)
      |=> (pending[REG1_LSB +: REG1_N]
         == ($past(pending[REG1_LSB +: REG1_N]) & ~$past(wdata_in[REG1_N-1:0]))))
      else $error("write to status1 did not clear exactly the one bits");

   a_clear_status2: assert property ( // RQ8
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && wr_in && addr_in == STATUS2_ADDR && set_vec == '0)
      |=> (pending[REG2_LSB +: REG2_N]
         == ($past(pending[REG2_LSB +: REG2_N]) & ~$past(wdata_in[REG2_N-1:0]))))
      else $error("write to status2 did not clear exactly the one bits");

   a_status0_readback: assert property ( // RQ3
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && rd_in && addr_in == STATUS0_ADDR)
      |=> (rdata_out == $past(pending[REG0_LSB +: REG0_N])))
      else $error("status0 read returned the wrong value");

   a_status2_readback: assert property ( // RQ3
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && rd_in && addr_in == STATUS2_ADDR)
      |=> (rdata_out[REG2_N-1:0] == $past(pending[REG2_LSB +: REG2_N])))
      else $error("status2 read returned the wrong value");

   a_enable1_readback: assert property ( // RQ2
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && rd_in && addr_in == ENABLE1_ADDR)
      |=> (rdata_out == {4'h0, $past(enable_ff[REG1_LSB +: REG1_N])}))
      else $error("enable1 read returned the wrong value");

   a_digit_readback: assert property ( // RQ9
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && rd_in && addr_in == DIGIT_ADDR)
      |=> (rdata_out == {4'h0, $past(digit)}))
      else $error("digit read returned the wrong value");

   a_enable_kept: assert property ( // RQ4
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && !wr_in) |=> $stable(enable_ff))
      else $error("enable register changed without a write");

   a_reserved_ignored: assert property ( // RQ2
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && wr_in && addr_in > DIGIT_ADDR) |=> $stable(enable_ff))
      else $error("write to the unused offset changed an enable");

   a_enable_keeps_status: assert property ( // RQ10
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ce_in && wr_in && addr_in != STATUS0_ADDR && addr_in != STATUS1_ADDR
         && addr_in != STATUS2_ADDR)
      |=> ((pending & $past(pending)) == $past(pending)))
      else $error("status bit dropped by a write elsewhere");

   a_pin_low_held: assert property ( // RQ6
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (!wr_in && !int_b_out) |=> !int_b_out)
      else $error("pin released without a status write");

endmodule // line_interface_interrupt_logic

`default_nettype wire

// File: irq_host_model.sv
// host interrupt handler model: reads all status on a low pin, clears what it saw
`timescale 1ns/1ns
`default_nettype none

module irq_host_model (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic en_in,
   input wire logic int_b_in,
   input wire logic [line_irq_pkg::DATA_W-1:0] rdata_in,
   output logic [line_irq_pkg::ADDR_W-1:0] addr_out,
   output logic [line_irq_pkg::DATA_W-1:0] wdata_out,
   output logic wr_out,
   output logic rd_out,
   output logic [15:0] serviced_out
);
   import line_irq_pkg::*;
   logic [DATA_W-1:0] seen [3];

   ////////////////////////////////////////////////////////////////////////////////
   // one service pass per low pin: read every status register, then clear them
   initial
   begin
      addr_out = '0;
      wdata_out = '0;
      wr_out = 1'b0;
      rd_out = 1'b0;
      serviced_out = '0;
      forever
      begin
         @(posedge ref_clk_in);
         if (rst_b_in === 1'b1 && en_in === 1'b1 && int_b_in === 1'b0)
         begin
            for (int r = 0; r < 3; r++)
            begin
               addr_out <= r[ADDR_W-1:0];
               rd_out <= 1'b1;
               @(posedge ref_clk_in);
               rd_out <= 1'b0;
               @(posedge ref_clk_in);
               seen[r] = rdata_in;
            end
            // write back only the bits seen, so later arrivals stay pending;
            // the strobe stays high over the three back to back writes
            wr_out <= 1'b1;
            for (int r = 0; r < 3; r++)
            begin
               addr_out <= r[ADDR_W-1:0];
               wdata_out <= seen[r];
               @(posedge ref_clk_in);
            end
            wr_out <= 1'b0;
            serviced_out <= serviced_out + 16'h0001;
         end
      end
   end
endmodule // irq_host_model
`default_nettype wire

// File: tb_line_interface_interrupt_logic.sv
// self-checking bench for the interrupt aggregation block
`timescale 1ns/1ns
`default_nettype none

module tb_line_interface_interrupt_logic;
   import line_irq_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic host_on = 1'b0;
   logic [2:0] tb_addr = 3'h0;
   logic [7:0] tb_wdata = 8'h00;
   logic tb_wr = 1'b0;
   logic tb_rd = 1'b0;
   logic [12:0] ev = 13'h0000;
   logic [3:0] dg = 4'h0;
   logic [2:0] h_addr;
   logic [7:0] h_wdata;
   logic h_wr;
   logic h_rd;
   logic [15:0] serviced;
   logic [7:0] rdata;
   logic int_b;
   int num_errors = 0;
   int total_checks = 0;

   always #4 ref_clk = ~ref_clk;

   line_interface_interrupt_logic u_dut (.ref_clk_in(ref_clk), .rst_b_in(rst_b), .ce_in(ce),
      .addr_in(host_on ? h_addr : tb_addr), .wdata_in(host_on ? h_wdata : tb_wdata),
      .wr_in(host_on ? h_wr : tb_wr), .rd_in(host_on ? h_rd : tb_rd), .rdata_out(rdata),
      .event_in(ev), .tone_digit_in(dg), .int_b_out(int_b));

   irq_host_model u_host (.ref_clk_in(ref_clk), .rst_b_in(rst_b), .en_in(host_on),
      .int_b_in(int_b), .rdata_in(rdata), .addr_out(h_addr), .wdata_out(h_wdata),
      .wr_out(h_wr), .rd_out(h_rd), .serviced_out(serviced));

   ////////////////////////////////////////////////////////////////////////////////
   // compare, verdict and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      if (num_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      tb_addr <= a;
      tb_wdata <= d;
      tb_wr <= 1'b1;
      @(posedge ref_clk);
      tb_wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      tb_addr <= a;
      tb_rd <= 1'b1;
      @(posedge ref_clk);
      tb_rd <= 1'b0;
      @(posedge ref_clk);
      d = rdata;
   endtask

   // three-register access spread over the 13-bit source vector
   task automatic put3(input logic [2:0] base, input logic [12:0] m);
      bus_wr(base, m[7:0]);
      bus_wr(base + 3'h1, {4'h0, m[11:8]});
      bus_wr(base + 3'h2, {7'h00, m[12]});
   endtask

   task automatic chk_stat(input logic [12:0] exp);
      logic [7:0] r0;
      logic [7:0] r1;
      logic [7:0] r2;
      bus_rd(STATUS0_ADDR, r0);
      bus_rd(STATUS1_ADDR, r1);
      bus_rd(STATUS2_ADDR, r2);
      chk({r2, r1, r0}, {7'h00, exp[12], 4'h0, exp[11:8], exp[7:0]});
      chk({15'h0000, int_b}, {15'h0000, exp == 13'h0000});
   endtask

   task automatic pulse(input logic [12:0] m, input logic [3:0] d);
      @(posedge ref_clk);
      ev <= m;
      dg <= d;
      @(posedge ref_clk);
      ev <= 13'h0000;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      logic [7:0] d;
      for (int a = 0; a < 8; a++)
      begin
         bus_rd(a[2:0], d);
         chk({8'h00, d}, 16'h0000);
      end
      put3(ENABLE0_ADDR, 13'h1FFF);
      bus_wr(3'h7, 8'hFF);
      bus_wr(DIGIT_ADDR, 8'h0F);
      bus_rd(ENABLE1_ADDR, d);
      chk({8'h00, d}, 16'h000F);
      bus_rd(ENABLE2_ADDR, d);
      chk({8'h00, d}, 16'h0001);
      bus_rd(3'h7, d);
      chk({8'h00, d}, 16'h0000);
      bus_rd(DIGIT_ADDR, d);
      chk({8'h00, d}, 16'h0000);
      // write then read enable0 back to back, then the idle read data
      @(posedge ref_clk);
      tb_addr <= ENABLE0_ADDR;
      tb_wdata <= 8'h5A;
      tb_wr <= 1'b1;
      @(posedge ref_clk);
      tb_wr <= 1'b0;
      tb_rd <= 1'b1;
      @(posedge ref_clk);
      tb_rd <= 1'b0;
      @(posedge ref_clk);
      chk({8'h00, rdata}, 16'h005A);
      @(posedge ref_clk);
      chk({8'h00, rdata}, 16'h0000);
   endtask

   task automatic t_gate;
      put3(ENABLE0_ADDR, 13'h0000);
      pulse(13'h1FFF, 4'h3);
      chk_stat(13'h0000);
      for (int i = 0; i < NUM_SRC; i++)
      begin
         put3(ENABLE0_ADDR, 13'h0001 << i);
         pulse(13'h1FFF, 4'h1);
         chk_stat(13'h0001 << i);
         put3(STATUS0_ADDR, 13'h0001 << i);
         chk_stat(13'h0000);
      end
   endtask

   task automatic t_sticky;
      put3(ENABLE0_ADDR, 13'h1FFF);
      pulse(13'h1208, 4'h7);
      repeat (5) @(posedge ref_clk);
      chk_stat(13'h1208);
      put3(ENABLE0_ADDR, 13'h0000);
      put3(STATUS0_ADDR, 13'h0200);
      chk_stat(13'h1008);
      put3(STATUS0_ADDR, 13'h0000);
      chk_stat(13'h1008);
      put3(STATUS0_ADDR, 13'h1FFF);
      chk_stat(13'h0000);
   endtask

   task automatic t_collide;
      put3(ENABLE0_ADDR, 13'h1FFF);
      pulse(13'h0001, 4'h0);
      @(posedge ref_clk);
      tb_addr <= STATUS0_ADDR;
      tb_wdata <= 8'h01;
      tb_wr <= 1'b1;
      ev <= 13'h0001;
      @(posedge ref_clk);
      tb_wr <= 1'b0;
      ev <= 13'h0000;
      chk_stat(13'h0001);
      @(posedge ref_clk);
      ce <= 1'b0;
      pulse(13'h0002, 4'h0);
      ce <= 1'b1;
      chk_stat(13'h0001);
      put3(STATUS0_ADDR, 13'h1FFF);
      chk_stat(13'h0000);
   endtask

   task automatic t_digit;
      logic [7:0] d;
      put3(ENABLE0_ADDR, 13'h0000);
      pulse(13'h1000, 4'h5);
      bus_rd(DIGIT_ADDR, d);
      chk({8'h00, d}, 16'h0005);
      chk_stat(13'h0000);
      put3(ENABLE0_ADDR, 13'h1000);
      pulse(13'h1000, 4'hA);
      bus_rd(DIGIT_ADDR, d);
      chk({8'h00, d}, 16'h000A);
      chk_stat(13'h1000);
      put3(STATUS0_ADDR, 13'h1000);
   endtask

   task automatic t_host;
      int n;
      put3(ENABLE0_ADDR, 13'h1FFF);
      @(posedge ref_clk);
      host_on <= 1'b1;
      pulse(13'h1104, 4'h2);
      @(posedge ref_clk);
      chk({15'h0000, int_b}, 16'h0000);
      n = 0;
      // pin low first, then a full read and clear pass brings it back high
      while ((int_b !== 1'b1 || serviced !== 16'h0001) && n < 60)
      begin
         @(posedge ref_clk);
         n++;
      end
      @(posedge ref_clk);
      host_on <= 1'b0;
      chk(serviced, 16'h0001);
      chk_stat(13'h0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_reset();
      t_gate();
      t_sticky();
      t_collide();
      t_digit();
      t_host();
      end_sim();
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      end_sim();
   end
endmodule // tb_line_interface_interrupt_logic
`default_nettype wire
